// ==== src/uep_cpu_if.sv ====
// CPU port between firmware master and endpoint register block
`timescale 1ns/100ps
`default_nettype none
interface uep_cpu_if;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic stall;
    logic setup_hold;
    modport dev (input addr, input wdata, input wr, input rd,
                 output rdata, output stall, output setup_hold);
    modport cpu (output addr, output wdata, output wr, output rd,
                 input rdata, input stall, input setup_hold);
endinterface : uep_cpu_if
`default_nettype wire

// ==== src/uep_dev_end.sv ====
// Endpoint configuration, endpoint-zero mode registers and FIFO RAM
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uep_regs.svh"
module uep_dev_end (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_CE,
    uep_cpu_if.dev CPU,
    input wire logic I_TOK_DONE,
    input wire uep_pkg::uep_token_t I_TOK,
    input wire logic I_TOK_ADDR_B,
    input wire logic I_SETUP_DATA,
    input wire logic I_ACK_START,
    input wire logic I_UPDATE,
    input wire logic I_UPD_ACKED,
    input wire logic I_UPD_MODE_WE,
    input wire logic [3:0] I_UPD_MODE,
    input wire logic I_BYTE_VALID,
    input wire logic [2:0] I_BYTE_EP,
    input wire logic [4:0] I_BYTE_IDX,
    input wire logic [7:0] I_BYTE_DATA,
    output logic O_BYTE_READY,
    output logic O_CFG_SIZE,
    output logic O_CFG_ADDR_MODE,
    output uep_pkg::uep_resp_t O_RESP,
    output logic [7:0] O_ADDR_A_ENDPOINT_ZERO_MODE,
    output logic [7:0] O_ADDR_B_ENDPOINT_ZERO_MODE
);
    import uep_pkg::*;

    // ==================================================
    // Helpers
    function automatic logic [7:0] fifo_base(input logic size, input logic [2:0] ep);
        logic [7:0] b;
        case (ep)
            3'h0: b = size ? `UEP_FB1_EP0 : `UEP_FB0_EP0;
            3'h1: b = size ? `UEP_FB1_EP1 : `UEP_FB0_EP1;
            3'h2: b = size ? `UEP_FB1_EP2 : `UEP_FB0_EP2;
            3'h3: b = size ? `UEP_FB1_EP3 : `UEP_FB0_EP3;
            default: b = size ? `UEP_FB1_EP4 : `UEP_FB0_EP4;
        endcase
        return b;
    endfunction : fifo_base

    function automatic logic [5:0] fifo_len(input logic size, input logic [2:0] ep);
        return (size && (ep == 3'h1 || ep == 3'h2)) ? `UEP_FIFO_LARGE : `UEP_FIFO_SMALL;
    endfunction : fifo_len

    function automatic logic in_fifo(input logic [7:0] a, input logic [7:0] base,
                                     input logic [5:0] len);
        logic [7:0] d;
        d = a - base;
        return d < {2'b00, len};
    endfunction : in_fifo

    function automatic uep_resp_t resp_of(input logic [3:0] mode, input uep_token_t tok);
        uep_resp_t r;
        if (tok == TOK_NONE) begin
            r = RESP_IGNORE;
        end else begin
            case (mode)
                `UEP_MODE_DISABLE: r = RESP_IGNORE;
                `UEP_MODE_NAK_IO: r = (tok == TOK_SETUP) ? RESP_ACCEPT : RESP_NAK;
                `UEP_MODE_STATUS_OUT: r = (tok == TOK_IN) ? RESP_STALL : RESP_ACCEPT;
                `UEP_MODE_STALL_IO: r = (tok == TOK_SETUP) ? RESP_ACCEPT : RESP_STALL;
                default: r = RESP_ACCEPT;
            endcase
        end
        return r;
    endfunction : resp_of

    // ==================================================
    // State
    logic [1:0] sc_r; // {size, addressing}
    logic [7:0] mode_r [2];
    logic [1:0] lock_r;
    logic [1:0] force_r;
    logic [1:0] force_nxt;
    logic [7:0] mode_nxt [2];
    logic [1:0] lock_nxt;
    logic [7:0] rdata_r;
    logic stall_r;
    logic hold_r;
    logic byte_rdy_r;
    logic [1:0] cnt_r;
    logic [7:0] pb_addr_r;
    logic [7:0] pb_data_r;
    uep_resp_t resp_r;
    logic [7:0] ram [256];

    // ==================================================
    // Decode
    wire cfg_size = sc_r[1];
    wire cfg_five = sc_r[0];
    wire [7:0] a8 = CPU.addr[7:0];
    wire is_ram = CPU.addr[`UEP_ADDR_RAM_BIT];
    wire wr_sc = CPU.wr && CPU.addr == `UEP_ADDR_SC;
    wire [1:0] wr_mode = {CPU.wr && CPU.addr == `UEP_ADDR_ADDR_B_ENDPOINT_ZERO_MODE,
                          CPU.wr && CPU.addr == `UEP_ADDR_ADDR_A_ENDPOINT_ZERO_MODE};
    wire [1:0] rd_mode = {CPU.rd && CPU.addr == `UEP_ADDR_ADDR_B_ENDPOINT_ZERO_MODE,
                          CPU.rd && CPU.addr == `UEP_ADDR_ADDR_A_ENDPOINT_ZERO_MODE};
    wire setup_a = mode_r[0][`UEP_MB_SETUP];
    wire setup_b = !cfg_five && mode_r[1][`UEP_MB_SETUP];
    wire prot_a = setup_a && in_fifo(a8, fifo_base(cfg_size, 3'h0), `UEP_FIFO_SMALL);
    wire prot_b = setup_b && in_fifo(a8, fifo_base(cfg_size, 3'h3), `UEP_FIFO_SMALL);
    wire ram_wr_ok = CPU.wr && is_ram && !prot_a && !prot_b;
    wire [5:0] blen = fifo_len(cfg_size, I_BYTE_EP);
    wire [4:0] bmask = 5'(blen - 6'h01);
    wire [7:0] baddr = fifo_base(cfg_size, I_BYTE_EP) + {3'b000, I_BYTE_IDX & bmask};
    wire byte_take = I_BYTE_VALID && byte_rdy_r && cnt_r == 2'h0;
    wire eng_wr = cnt_r == 2'h1; // Last stall cycle, CPU is idle by then
    wire [1:0] cnt_nxt = byte_take ? `UEP_STALL_CYCLES : (cnt_r != 2'h0 ? cnt_r - 2'h1 : 2'h0);
    wire [7:0] rd_nxt = is_ram ? ram[a8] :
                        CPU.addr == `UEP_ADDR_SC ? {sc_r, 6'h00} :
                        rd_mode[0] ? mode_r[0] :
                        rd_mode[1] ? mode_r[1] : 8'h00;

    // ==================================================
    // Endpoint-zero mode registers (index 0 address A, index 1 address B)
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ep0
            wire ctl = (gi == 0) || !cfg_five;
            wire hit = I_TOK_ADDR_B == 1'(gi);
            wire tok_ev = I_TOK_DONE && hit && ctl;
            wire upd_ev = I_UPDATE && hit;
            wire eng_ev = tok_ev || (upd_ev && ctl);
            wire set_setup = (tok_ev && I_TOK == TOK_SETUP) || (I_SETUP_DATA && hit && ctl);
            wire cpu_lo_ok = wr_mode[gi] && (!ctl || (!lock_r[gi] && !eng_ev));
            wire [6:0] lo = cpu_lo_ok ? CPU.wdata[6:0] : mode_r[gi][6:0];
            wire b7 = ctl ? (set_setup || force_r[gi] || (mode_r[gi][7] && !wr_mode[gi]))
                          : (wr_mode[gi] ? CPU.wdata[7] : mode_r[gi][7]);
            wire b6 = tok_ev ? I_TOK == TOK_IN : lo[6];
            wire b5 = tok_ev ? I_TOK == TOK_OUT : lo[5];
            wire b4 = (upd_ev && I_UPD_ACKED) || lo[4];
            wire setup_nak = tok_ev && I_TOK == TOK_SETUP && mode_r[gi][3:0] != `UEP_MODE_DISABLE;
            wire [3:0] md = (upd_ev && I_UPD_MODE_WE) ? I_UPD_MODE :
                            setup_nak ? `UEP_MODE_NAK_IO : lo[3:0];
            assign mode_nxt[gi] = {b7, b6, b5, b4, md};
            assign lock_nxt[gi] = ctl && (eng_ev || (lock_r[gi] && !rd_mode[gi]));
            assign force_nxt[gi] = ctl && ((I_SETUP_DATA && hit) ||
                                           (force_r[gi] && !(I_ACK_START && hit)));

            always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
                if (I_RST) begin
                    mode_r[gi] <= `UEP_MODE_RST;
                    lock_r[gi] <= 1'b0;
                    force_r[gi] <= 1'b0;
                end else if (I_CE) begin
                    mode_r[gi] <= mode_nxt[gi];
                    lock_r[gi] <= lock_nxt[gi];
                    force_r[gi] <= force_nxt[gi];
                end
            end
        end
    endgenerate

    // ==================================================
    // Configuration, read data, engine byte path
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            sc_r <= `UEP_SC_RST;
            rdata_r <= 8'h00;
            stall_r <= 1'b0;
            hold_r <= 1'b0;
            byte_rdy_r <= 1'b0;
            cnt_r <= 2'h0;
            pb_addr_r <= 8'h00;
            pb_data_r <= 8'h00;
            resp_r <= RESP_IGNORE;
        end else if (I_CE) begin
            if (wr_sc) begin
                sc_r <= CPU.wdata[`UEP_SC_SIZE_BIT:`UEP_SC_ADDR_MODE_BIT];
            end
            rdata_r <= CPU.rd ? rd_nxt : 8'h00;
            cnt_r <= cnt_nxt;
            stall_r <= cnt_nxt != 2'h0;
            byte_rdy_r <= cnt_nxt == 2'h0;
            hold_r <= |force_nxt;
            if (byte_take) begin
                pb_addr_r <= baddr;
                pb_data_r <= I_BYTE_DATA;
            end
            resp_r <= resp_of(I_TOK_ADDR_B ? mode_r[1][3:0] : mode_r[0][3:0], I_TOK);
        end
    end

    // FIFO RAM, engine write has priority
    always_ff @(posedge I_CLK_SYS) begin
        if (I_CE) begin
            if (eng_wr) begin
                ram[pb_addr_r] <= pb_data_r;
            end else if (ram_wr_ok) begin
                ram[a8] <= CPU.wdata;
            end
        end
    end

    assign CPU.rdata = rdata_r;
    assign CPU.stall = stall_r;
    assign CPU.setup_hold = hold_r;
    assign O_BYTE_READY = byte_rdy_r;
    assign O_CFG_SIZE = sc_r[1];
    assign O_CFG_ADDR_MODE = sc_r[0];
    assign O_RESP = resp_r;
    assign O_ADDR_A_ENDPOINT_ZERO_MODE = mode_r[0];
    assign O_ADDR_B_ENDPOINT_ZERO_MODE = mode_r[1];
endmodule : uep_dev_end
`default_nettype wire

// ==== src/uep_fw_end.sv ====
// Firmware-side master that accesses the endpoint registers safely
`timescale 1ns/100ps
`default_nettype none
`include "uep_regs.svh"
module uep_fw_end (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_CE,
    uep_cpu_if.cpu CPU,
    input wire logic I_CMD_WR,
    input wire logic I_CMD_RD,
    input wire logic [8:0] I_CMD_ADDR,
    input wire logic [7:0] I_CMD_DATA,
    output logic O_BUSY,
    output logic O_DONE,
    output logic [7:0] O_RDATA,
    output logic O_VERIFY_FAIL
);
    import uep_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PRE_RD, ST_PRE_WAIT, ST_PRE_CAP, ST_WR, ST_FIN, ST_RD, ST_RD_WAIT, ST_RD_CAP
    } uep_fw_state_t;

    uep_fw_state_t state_r;
    logic [8:0] addr_r;
    logic [7:0] data_r;
    logic wr_r;
    logic rd_r;
    logic post_r;
    logic busy_r;
    logic done_r;
    logic fail_r;
    logic [7:0] rdata_r;

    // ==================================================
    // Decode
    wire is_ep0 = addr_r == `UEP_ADDR_ADDR_A_ENDPOINT_ZERO_MODE || addr_r == `UEP_ADDR_ADDR_B_ENDPOINT_ZERO_MODE;
    wire cmd_ep0 = I_CMD_ADDR == `UEP_ADDR_ADDR_A_ENDPOINT_ZERO_MODE || I_CMD_ADDR == `UEP_ADDR_ADDR_B_ENDPOINT_ZERO_MODE;
    wire go = !CPU.stall;

    // ==================================================
    // Sequencer
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            state_r <= ST_IDLE;
            addr_r <= 9'h000;
            data_r <= 8'h00;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            post_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (I_CE) begin
            done_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    post_r <= 1'b0;
                    if (I_CMD_WR || I_CMD_RD) begin
                        addr_r <= I_CMD_ADDR;
                        data_r <= I_CMD_DATA;
                        busy_r <= 1'b1;
                        state_r <= !I_CMD_WR ? ST_RD : (cmd_ep0 ? ST_PRE_RD : ST_WR);
                    end
                end
                ST_PRE_RD: begin
                    if (go) begin
                        rd_r <= 1'b1;
                        state_r <= ST_PRE_WAIT;
                    end
                end
                ST_PRE_WAIT: state_r <= ST_PRE_CAP;
                ST_PRE_CAP: begin
                    // Re-read while the engine forces SETUP high
                    state_r <= CPU.setup_hold ? ST_PRE_RD : ST_WR;
                end
                ST_WR: begin
                    if (go) begin
                        wr_r <= 1'b1;
                        post_r <= is_ep0;
                        state_r <= is_ep0 ? ST_RD : ST_FIN;
                    end
                end
                ST_FIN: begin
                    done_r <= 1'b1;
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                ST_RD: begin
                    if (go) begin
                        rd_r <= 1'b1;
                        state_r <= ST_RD_WAIT;
                    end
                end
                ST_RD_WAIT: state_r <= ST_RD_CAP;
                ST_RD_CAP: begin
                    rdata_r <= CPU.rdata;
                    fail_r <= post_r && CPU.rdata[6:0] != data_r[6:0];
                    done_r <= 1'b1;
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign CPU.addr = addr_r;
    assign CPU.wdata = data_r;
    assign CPU.wr = wr_r;
    assign CPU.rd = rd_r;
    assign O_BUSY = busy_r;
    assign O_DONE = done_r;
    assign O_RDATA = rdata_r;
    assign O_VERIFY_FAIL = fail_r;
endmodule : uep_fw_end
`default_nettype wire

// ==== src/uep_pkg.sv ====
// Types shared by both ends of the endpoint block
package uep_pkg;
    typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT, TOK_NONE} uep_token_t;
    typedef enum logic [1:0] {RESP_IGNORE, RESP_ACCEPT, RESP_NAK, RESP_STALL} uep_resp_t;
endpackage : uep_pkg

// ==== src/uep_regs.svh ====
// Register offsets, field positions, FIFO map and timing for the endpoint block
// Notes on behaviour
// - Config bit7 sets FIFO size, bit6 addressing
// - Small FIFOs 0xD8..0xF8, endpoint zero at 0xF8
// - Large layout: 8-byte 0xA8..0xB8, 32-byte 0xC0/0xE0
// - Each engine FIFO byte stalls CPU three cycles
// - Endpoint zero flags both IN and OUT
// - Endpoint mode registers reset to zero
// - Configs [0,0]/[1,0] use control layout for both
// - Mode field bits 3..0 choose bus response
// - ACK-completed transaction sets bit 4
// - OUT token sets bit 5; firmware clears it
// - IN token sets bit 6; firmware clears it
// - Only engine sets SETUP; CPU write clears it
// - SETUP forced from data packet until ACK
// - Firmware reads before clearing SETUP, never while forced
// - Engine update locks bits 6..0 until CPU read
// - Lock applies only to endpoint-zero registers
// - Firmware reads back every endpoint-zero write
// - SETUP set blocks CPU writes to endpoint-zero FIFOs
// - Five-endpoint mode makes 0x42 non-control endpoint three
// - Mode 0000 ignores all; 0001 accepts SETUP, NAKs
`ifndef UEP_REGS_SVH
`define UEP_REGS_SVH

// ==================================================
// CPU port map (bit 8 selects data RAM)
`define UEP_ADDR_SC 9'h01f
`define UEP_ADDR_ADDR_A_ENDPOINT_ZERO_MODE 9'h012
`define UEP_ADDR_ADDR_B_ENDPOINT_ZERO_MODE 9'h042
`define UEP_ADDR_RAM_BIT 8

// ==================================================
// Field positions and reset values
`define UEP_SC_SIZE_BIT 7
`define UEP_SC_ADDR_MODE_BIT 6
`define UEP_MB_SETUP 7
`define UEP_MB_IN 6
`define UEP_MB_OUT 5
`define UEP_MB_ACK 4
`define UEP_MODE_RST 8'h00
`define UEP_SC_RST 2'h0

// ==================================================
// Mode field encodings
`define UEP_MODE_DISABLE 4'h0
`define UEP_MODE_NAK_IO 4'h1
`define UEP_MODE_STATUS_OUT 4'h2
`define UEP_MODE_STALL_IO 4'h3

// ==================================================
// FIFO placement, size bit clear
`define UEP_FB0_EP0 8'hf8
`define UEP_FB0_EP1 8'hf0
`define UEP_FB0_EP2 8'he8
`define UEP_FB0_EP3 8'he0
`define UEP_FB0_EP4 8'hd8
// FIFO placement, size bit set
`define UEP_FB1_EP0 8'hb8
`define UEP_FB1_EP1 8'hc0
`define UEP_FB1_EP2 8'he0
`define UEP_FB1_EP3 8'ha8
`define UEP_FB1_EP4 8'hb0
`define UEP_FIFO_SMALL 6'h08
`define UEP_FIFO_LARGE 6'h20

// ==================================================
// Timing
`define UEP_STALL_CYCLES 2'h3

`endif

// ==== tb/uep_link_asserts.sv ====
// Concurrent checks on the CPU port and the endpoint-zero mode registers
`timescale 1ns/100ps
`default_nettype none
module uep_link_asserts
    import uep_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic [8:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic stall,
    input wire logic setup_hold,
    input wire logic I_TOK_DONE,
    input wire uep_pkg::uep_token_t I_TOK,
    input wire logic I_TOK_ADDR_B,
    input wire logic I_SETUP_DATA,
    input wire logic I_UPDATE,
    input wire logic [7:0] O_ADDR_A_ENDPOINT_ZERO_MODE,
    input wire logic [7:0] O_ADDR_B_ENDPOINT_ZERO_MODE
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST || !I_CE);
    wire tok_a = I_TOK_DONE && !I_TOK_ADDR_B;
    wire wr_a0 = wr && addr == 9'h012;
    // ==========================================
    // Port timing
    AST_NO_BOTH: assert property (!(wr && rd))
        else $error("write and read strobes together");
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_STALL_LEN: assert property ($rose(stall) |-> stall [*3] ##1 !stall)
        else $error("stall not three cycles");
    // ==========================================
    // Endpoint-zero flags and lock
    AST_IN_FLAG: assert property (tok_a && I_TOK == TOK_IN |=> O_ADDR_A_ENDPOINT_ZERO_MODE[6:5] == 2'b10)
        else $error("IN token flags wrong");
    AST_OUT_FLAG: assert property (tok_a && I_TOK == TOK_OUT |=> O_ADDR_A_ENDPOINT_ZERO_MODE[6:5] == 2'b01)
        else $error("OUT token flags wrong");
    AST_SETUP_SET: assert property (I_SETUP_DATA && !I_TOK_ADDR_B |=> O_ADDR_A_ENDPOINT_ZERO_MODE[7])
        else $error("SETUP flag not set by data packet");
    AST_HOLD_SRC: assert property (setup_hold |-> O_ADDR_A_ENDPOINT_ZERO_MODE[7] || O_ADDR_B_ENDPOINT_ZERO_MODE[7])
        else $error("setup hold without SETUP flag");
    AST_CPU_CLR: assert property (wr_a0 && !setup_hold && !I_SETUP_DATA && !I_TOK_DONE
        && !$past(I_SETUP_DATA) |=> !O_ADDR_A_ENDPOINT_ZERO_MODE[7])
        else $error("CPU write did not clear SETUP flag");
    AST_LOCK: assert property ((tok_a && !rd) ##1 (wr_a0 && !rd && !I_TOK_DONE && !I_UPDATE)
        |=> $stable(O_ADDR_A_ENDPOINT_ZERO_MODE[6:0]))
        else $error("locked bits took a CPU write");
    COV_LOCK: cover property (tok_a ##1 wr_a0);
    COV_STALL: cover property ($rose(stall));
    COV_HOLD: cover property ($rose(setup_hold));
endmodule : uep_link_asserts
`default_nettype wire

// ==== tb/usb_endpoint_config_ep0_mode_test.sv ====
// Self-checking bench joining firmware end and device end
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_config_ep0_mode_test;
    import uep_pkg::*;
    logic clk_sys, rst, tok_done, tok_b, setup_data, ack_start, upd, upd_acked, upd_we;
    logic byte_valid, byte_ready, cfg_size, cfg_mode, cmd_wr, cmd_rd, busy, done, vfail;
    logic [3:0] upd_mode;
    logic [2:0] byte_ep;
    logic [4:0] byte_idx;
    logic [7:0] byte_data, cmd_data, addr_a_endpoint_zero, addr_b_endpoint_zero, fw_rdata, a;
    logic [8:0] cmd_addr, m, e;
    logic [31:0] r;
    logic ce;
    uep_token_t tok;
    uep_resp_t resp;
    logic [8:0] exp_q[$], msk_q[$];
    logic [8:0] rst_addr [4] = '{9'h012, 9'h042, 9'h01f, 9'h033};
    logic [7:0] bases [6] = '{8'hf8, 8'hf0, 8'he8, 8'hb8, 8'hc0, 8'he0};
    uep_resp_t resp_tab [4] = '{RESP_IGNORE, RESP_NAK, RESP_STALL, RESP_STALL};
    int fail_count = 0, tests_run = 0, seed;
    uep_cpu_if uep_cpu_if_i();
    uep_dev_end uep_dev_end_i (.I_CLK_SYS(clk_sys), .I_RST(rst), .I_CE(ce),
        .CPU(uep_cpu_if_i.dev), .I_TOK_DONE(tok_done), .I_TOK(tok), .I_TOK_ADDR_B(tok_b),
        .I_SETUP_DATA(setup_data), .I_ACK_START(ack_start), .I_UPDATE(upd),
        .I_UPD_ACKED(upd_acked), .I_UPD_MODE_WE(upd_we), .I_UPD_MODE(upd_mode),
        .I_BYTE_VALID(byte_valid), .I_BYTE_EP(byte_ep), .I_BYTE_IDX(byte_idx),
        .I_BYTE_DATA(byte_data), .O_BYTE_READY(byte_ready), .O_CFG_SIZE(cfg_size),
        .O_CFG_ADDR_MODE(cfg_mode), .O_RESP(resp), .O_ADDR_A_ENDPOINT_ZERO_MODE(addr_a_endpoint_zero), .O_ADDR_B_ENDPOINT_ZERO_MODE(addr_b_endpoint_zero));
    uep_fw_end uep_fw_end_i (.I_CLK_SYS(clk_sys), .I_RST(rst), .I_CE(ce),
        .CPU(uep_cpu_if_i.cpu), .I_CMD_WR(cmd_wr), .I_CMD_RD(cmd_rd), .I_CMD_ADDR(cmd_addr),
        .I_CMD_DATA(cmd_data), .O_BUSY(busy), .O_DONE(done), .O_RDATA(fw_rdata),
        .O_VERIFY_FAIL(vfail));
    uep_link_asserts uep_link_asserts_i (.I_CLK_SYS(clk_sys), .I_RST(rst), .I_CE(ce),
        .addr(uep_cpu_if_i.addr), .wr(uep_cpu_if_i.wr), .rd(uep_cpu_if_i.rd),
        .rdata(uep_cpu_if_i.rdata), .stall(uep_cpu_if_i.stall),
        .setup_hold(uep_cpu_if_i.setup_hold), .I_TOK_DONE(tok_done), .I_TOK(tok),
        .I_TOK_ADDR_B(tok_b), .I_SETUP_DATA(setup_data), .I_UPDATE(upd),
        .O_ADDR_A_ENDPOINT_ZERO_MODE(addr_a_endpoint_zero), .O_ADDR_B_ENDPOINT_ZERO_MODE(addr_b_endpoint_zero));
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [8:0] got, input logic [8:0] expv);
        tests_run++;
        if (got !== expv) begin
            fail_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, expv);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // Firmware command; expected {verify_fail, rdata} under mask noted first
    task automatic cmd(input logic w, input logic [8:0] ad, input logic [7:0] d,
                       input logic [8:0] ex, input logic [8:0] mk);
        int n;
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        @(posedge clk_sys);
        cmd_wr <= w;
        cmd_rd <= !w;
        cmd_addr <= ad;
        cmd_data <= d;
        @(posedge clk_sys);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
        @(negedge clk_sys);
        chk({8'h0, busy}, 9'h001);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (done !== 1'b1 && n < 200);
        chk({7'h0, busy, done}, 9'h001);
    endtask : cmd
    task automatic tokev(input uep_token_t t, input logic b);
        @(posedge clk_sys);
        tok_done <= 1'b1;
        tok <= t;
        tok_b <= b;
        @(posedge clk_sys);
        tok_done <= 1'b0;
        tok <= TOK_NONE;
        @(negedge clk_sys);
    endtask : tokev
    task automatic put_byte(input logic [2:0] ep, input logic [4:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        byte_valid <= 1'b1;
        byte_ep <= ep;
        byte_idx <= idx;
        byte_data <= d;
        @(posedge clk_sys);
        byte_valid <= 1'b0;
        n = 0;
        repeat (5) begin
            @(negedge clk_sys);
            n += int'(byte_ready === 1'b0);
        end
        chk(9'(n), 9'h003);
    endtask : put_byte
    // ==========================================
    // Result monitor
    always @(negedge clk_sys) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(9'h1ff, 9'h000);
            end else begin
                m = msk_q.pop_front();
                e = exp_q.pop_front();
                chk({vfail, fw_rdata} & m, e & m);
            end
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        conclude();
    end
    // ==========================================
    // Main sequence
    initial begin
        seed = 30;
        {rst, tok_done, tok_b, setup_data, ack_start, upd, upd_acked, upd_we} = 8'hff;
        {tok_done, tok_b, setup_data, ack_start, upd, upd_acked, upd_we} = 7'h00;
        {byte_valid, byte_ep, byte_idx, byte_data, upd_mode} = 21'h0;
        {cmd_wr, cmd_rd, cmd_addr, cmd_data} = 19'h0;
        tok = TOK_NONE;
        ce = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rst_addr[i]) cmd(1'b0, rst_addr[i], 8'h00, 9'h000, 9'h1ff);
        r = $random(seed);
        cmd(1'b1, 9'h01f, r[7:0], 9'h000, 9'h000);
        cmd(1'b0, 9'h01f, 8'h00, {1'b0, r[7:6], 6'h00}, 9'h0ff);
        chk({7'h0, cfg_size, cfg_mode}, {7'h0, r[7:6]});
        $display("test reset and config done");
        for (int s = 0; s < 2; s++) begin
            cmd(1'b1, 9'h01f, s ? 8'h80 : 8'h00, 9'h000, 9'h000);
            for (int ep = 0; ep < 3; ep++) begin
                r = $random(seed);
                put_byte(3'(ep), r[12:8], r[7:0]);
                a = bases[s * 3 + ep] + {3'h0, r[12:8] & ((s && ep > 0) ? 5'h1f : 5'h07)};
                cmd(1'b0, {1'b1, a}, 8'h00, {1'b0, r[7:0]}, 9'h0ff);
            end
        end
        $display("test fifo map done");
        cmd(1'b1, 9'h01f, 8'h00, 9'h000, 9'h000);
        cmd(1'b1, 9'h1f8, 8'h11, 9'h000, 9'h000);
        @(posedge clk_sys);
        setup_data <= 1'b1;
        @(posedge clk_sys);
        setup_data <= 1'b0;
        cmd(1'b1, 9'h1f8, 8'h22, 9'h000, 9'h000);
        @(posedge clk_sys);
        ack_start <= 1'b1;
        @(posedge clk_sys);
        ack_start <= 1'b0;
        cmd(1'b0, 9'h1f8, 8'h00, 9'h011, 9'h0ff);
        cmd(1'b1, 9'h012, 8'h00, 9'h000, 9'h1ff);
        chk({1'b0, addr_a_endpoint_zero}, 9'h000);
        // Write issued while SETUP is forced must wait for the force to end
        @(posedge clk_sys);
        setup_data <= 1'b1;
        @(posedge clk_sys);
        setup_data <= 1'b0;
        fork
            cmd(1'b1, 9'h012, 8'h00, 9'h000, 9'h1ff);
            begin
                repeat (12) @(posedge clk_sys);
                ack_start <= 1'b1;
                @(posedge clk_sys);
                ack_start <= 1'b0;
            end
        join
        chk({1'b0, addr_a_endpoint_zero}, 9'h000);
        $display("test setup guard done");
        for (int k = 0; k < 4; k++) begin
            cmd(1'b1, 9'h012, 8'(k), 9'(k), 9'h1ff);
            @(posedge clk_sys);
            tok <= TOK_IN;
            repeat (2) @(negedge clk_sys);
            chk({7'h0, resp}, {7'h0, resp_tab[k]});
            @(posedge clk_sys);
            tok <= TOK_NONE;
        end
        @(posedge clk_sys);
        {upd, upd_acked, upd_we, upd_mode} <= 7'h71;
        @(posedge clk_sys);
        {upd, upd_acked, upd_we, upd_mode} <= 7'h00;
        @(negedge clk_sys);
        chk({1'b0, addr_a_endpoint_zero}, 9'h011);
        $display("test mode field done");
        fork
            cmd(1'b1, 9'h012, 8'h03, 9'h151, 9'h1ef);
            begin
                repeat (4) @(posedge clk_sys);
                tokev(TOK_IN, 1'b0);
            end
        join
        tokev(TOK_OUT, 1'b0);
        chk({7'h0, addr_a_endpoint_zero[6:5]}, 9'h001);
        $display("test lock done");
        cmd(1'b1, 9'h01f, 8'h40, 9'h000, 9'h000);
        cmd(1'b1, 9'h042, 8'h60, 9'h060, 9'h17f);
        tokev(TOK_IN, 1'b1);
        chk({1'b0, addr_b_endpoint_zero}, 9'h060);
        $display("test five endpoint done");
        // Token while the clock enable is low must leave the flags alone
        @(posedge clk_sys);
        ce <= 1'b0;
        tokev(TOK_IN, 1'b0);
        @(posedge clk_sys);
        ce <= 1'b1;
        @(negedge clk_sys);
        chk({7'h0, addr_a_endpoint_zero[6:5]}, 9'h001);
        $display("test clock enable done");
        conclude();
    end
endmodule : usb_endpoint_config_ep0_mode_test
`default_nettype wire
